// File: src/tsw_pkg.sv
package tsw_pkg;
    // Register offsets on the byte-wide configuration port
    localparam logic [7:0] FAST_MODES_ADDR = 8'h00;
    localparam logic [7:0] SIDE_MODES_ADDR = 8'h01;
    localparam logic [7:0] RX_SETTINGS_ADDR = 8'h10;
    localparam logic [7:0] TERM_PULSE_AB_ADDR = 8'h11;
    localparam logic [7:0] TERM_PULSE_CD_ADDR = 8'h12;
    localparam logic [7:0] EQ_SEL_AB_ADDR = 8'h13;
    localparam logic [7:0] EQ_SEL_CD_ADDR = 8'h14;
    localparam logic [7:0] TX_SETTINGS_ADDR = 8'h20;

    // Reset values
    localparam logic [7:0] FAST_MODES_RST = 8'h40;
    localparam logic [7:0] SIDE_MODES_RST = 8'h40;
    localparam logic [7:0] RX_SETTINGS_RST = 8'h01;
    localparam logic [7:0] TERM_PULSE_RST = 8'h00;
    localparam logic [7:0] EQ_SEL_RST = 8'h00;
    localparam logic [7:0] TX_SETTINGS_RST = 8'h03;

    // Field positions in the two mode registers
    localparam int MODE_EN_BIT = 6;
    localparam int MODE_SM_LSB = 4;
    localparam int MODE_CH_LSB = 0;
    // Field positions in the transmitter and receiver settings
    localparam int OUTPUT_EMPHASIS_LEVEL_LSB = 2;
    localparam int OUTPUT_TERMINATION_ON_BIT = 1;
    localparam int OUTPUT_CURRENT_LEVEL_BIT = 0;
    localparam int RX_TO_BIT = 0;

    // Termination pulse length
    localparam int PULSE_MS = 100;
    localparam longint CLOCK_HZ = 64'd200000000;
    localparam int PULSE_CYCLES = int'((64'(PULSE_MS) * CLOCK_HZ) / 64'd1000);

    // Bundling modes in field order; code 3 is never stored
    typedef enum logic [1:0] {
        TSW_MODE_QUAD,
        TSW_MODE_DUAL,
        TSW_MODE_SINGLE
    } tsw_mode_e;
    localparam logic [1:0] MODE_ILLEGAL = 2'h3;

    // One switch's routing: per output lane, on flag and input channel index
    typedef struct packed {
        logic [3:0] on;
        logic [3:0][3:0] chan;
    } tsw_route_s;

    // Output transmitter settings
    typedef struct packed {
        logic [1:0] output_emphasis_level;
        logic output_termination_on;
        logic output_current_level;
    } tsw_tx_s;
endpackage

// File: src/tsw_config_regs.sv
`timescale 1ns/1ps
// Contract
// [R1] Fast enable 0 turns all fast channels off (standby); 1 turns them on.
// [R2] Fast mode 00 quad, 01 dual, 10 single.
// [R3] Writing 11 to fast mode is illegal; previous mode kept.
// [R4] Quad: low two select bits pick source A-D for all four outputs.
// [R5] Dual: low three bits pick a channel pair; even low outputs, odd high.
// [R6] Single: four select bits pick one channel A0 through D3.
// [R7] Side enable 0 connects no side input; 1 turns side switch on.
// [R8] Side mode 00 quad, 01 dual, 10 single.
// [R9] Writing 11 to side mode is illegal; previous mode kept.
// [R10] Termination pulse bits: A/B at 0x11, C/D at 0x12, reset 0x00.
// [R11] A set pulse bit briefly disconnects that channel's termination on switch.
// [R12] Equalizer bits: A/B at 0x13, C/D at 0x14, reset 0x00.
// [R13] Pulse bit 1 disconnects termination 100 ms after switch; 0 keeps it.
// [R14] Equalizer bit 0 selects 6 dB, 1 selects 12 dB.
// [R15] Side quad: low two select bits route side source A-D.
// [R16] Emphasis field 00/01/10/11 gives 0/2/4/6 dB.
// [R17] Rejected mode write still updates enable and source select.
// [R18] Reset returns every register to its default before any access.
module tsw_config_regs #(
    parameter int PULSE_CYCLES = tsw_pkg::PULSE_CYCLES,
    parameter int CNT_W = 25
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    output tsw_pkg::tsw_route_s fast_route,
    output tsw_pkg::tsw_route_s side_route,
    output logic fast_standby,
    output logic [15:0] input_termination_on,
    output logic [15:0] equalizer_level_select,
    output tsw_pkg::tsw_tx_s tx_settings
);
    logic [7:0] fast_modes_q;
    logic [7:0] side_modes_q;
    logic [7:0] rx_settings_q;
    logic [15:0] term_pulse_select_q;
    logic [15:0] eq_sel_q;
    logic [7:0] tx_settings_q;
    logic [CNT_W-1:0] pulse_cnt_q;
    tsw_pkg::tsw_route_s fast_route_d;
    tsw_pkg::tsw_route_s side_route_d;
    tsw_pkg::tsw_route_s fast_route_q;
    tsw_pkg::tsw_route_s side_route_q;
    tsw_pkg::tsw_route_s fast_prev_q;
    logic pulse_active;
    logic switch_event;

    // Merge a mode-register write: an illegal mode code keeps the old mode
    // while the enable and source-select bits still take the new value.
    function automatic logic [7:0] merge_modes(input logic [7:0] old_v, input logic [7:0] new_v);
        logic [7:0] r;
        r = new_v;
        if (new_v[tsw_pkg::MODE_SM_LSB +: 2] == tsw_pkg::MODE_ILLEGAL) begin
            r[tsw_pkg::MODE_SM_LSB +: 2] = old_v[tsw_pkg::MODE_SM_LSB +: 2]; // [R3] [R9]
        end
        return r; // [R17]
    endfunction

    // Routing decode shared by the fast and side switches; the side dual mode
    // pairs A/B with C/D rather than even/odd neighbours.
    function automatic tsw_pkg::tsw_route_s decode_route(input logic [7:0] modes,
                                                         input logic is_side);
        tsw_pkg::tsw_route_s r;
        logic [3:0] sel;
        sel = modes[tsw_pkg::MODE_CH_LSB +: 4];
        r.on = modes[tsw_pkg::MODE_EN_BIT] ? 4'hf : 4'h0; // [R1] [R7]
        r.chan = '0;
        unique case (tsw_pkg::tsw_mode_e'(modes[tsw_pkg::MODE_SM_LSB +: 2]))
            tsw_pkg::TSW_MODE_QUAD: begin // [R2] [R8]
                for (int i = 0; i < 4; i++) begin
                    r.chan[i] = {sel[1:0], 2'(i)}; // [R4] [R15]
                end
            end
            tsw_pkg::TSW_MODE_DUAL: begin
                if (is_side) begin
                    r.chan[0] = {1'b0, sel[2:0]};
                    r.chan[1] = {1'b0, sel[2:0]};
                    r.chan[2] = {1'b1, sel[2:0]};
                    r.chan[3] = {1'b1, sel[2:0]};
                end else begin
                    r.chan[0] = {sel[2:0], 1'b0}; // [R5]
                    r.chan[1] = {sel[2:0], 1'b0};
                    r.chan[2] = {sel[2:0], 1'b1};
                    r.chan[3] = {sel[2:0], 1'b1};
                end
            end
            tsw_pkg::TSW_MODE_SINGLE: begin
                for (int i = 0; i < 4; i++) begin
                    r.chan[i] = sel; // [R6]
                end
            end
            default: begin
                // Unreachable: the merge never stores the illegal code
                r.on = 4'h0;
            end
        endcase
        return r;
    endfunction

    // Register bit that serves input channel ch (A0=0 .. D3=15); the A/B byte
    // holds B first, the C/D byte holds C first with each source's channels in reverse order.
    function automatic logic [3:0] chan_bit(input logic [3:0] ch);
        logic [3:0] r;
        unique case (ch[3:2])
            2'h0: r = {2'h1, ch[1:0]};
            2'h1: r = {2'h0, ch[1:0]};
            2'h2: r = 4'hb - {2'h0, ch[1:0]};
            2'h3: r = 4'hf - {2'h0, ch[1:0]};
        endcase
        return r;
    endfunction

    // Mode registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fast_modes_q <= tsw_pkg::FAST_MODES_RST; // [R18]
            side_modes_q <= tsw_pkg::SIDE_MODES_RST;
        end else if (reg_wr_en) begin
            if (reg_addr == tsw_pkg::FAST_MODES_ADDR) begin
                fast_modes_q <= merge_modes(fast_modes_q, reg_wr_data); // [R3]
            end
            if (reg_addr == tsw_pkg::SIDE_MODES_ADDR) begin
                side_modes_q <= merge_modes(side_modes_q, reg_wr_data); // [R9]
            end
        end
    end

    // Receiver, equalizer and transmitter registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_settings_q <= tsw_pkg::RX_SETTINGS_RST;
            term_pulse_select_q <= {tsw_pkg::TERM_PULSE_RST, tsw_pkg::TERM_PULSE_RST}; // [R10]
            eq_sel_q <= {tsw_pkg::EQ_SEL_RST, tsw_pkg::EQ_SEL_RST}; // [R12]
            tx_settings_q <= tsw_pkg::TX_SETTINGS_RST;
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                tsw_pkg::RX_SETTINGS_ADDR: begin
                    rx_settings_q <= {7'h00, reg_wr_data[tsw_pkg::RX_TO_BIT]};
                end
                tsw_pkg::TERM_PULSE_AB_ADDR: term_pulse_select_q[7:0] <= reg_wr_data; // [R10]
                tsw_pkg::TERM_PULSE_CD_ADDR: term_pulse_select_q[15:8] <= reg_wr_data;
                tsw_pkg::EQ_SEL_AB_ADDR: eq_sel_q[7:0] <= reg_wr_data; // [R12]
                tsw_pkg::EQ_SEL_CD_ADDR: eq_sel_q[15:8] <= reg_wr_data;
                tsw_pkg::TX_SETTINGS_ADDR: tx_settings_q <= {4'h0, reg_wr_data[3:0]};
                default: begin
                    // Writes to other offsets are ignored
                end
            endcase
        end
    end

    // Read port: one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rd_data <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                unique case (reg_addr)
                    tsw_pkg::FAST_MODES_ADDR: reg_rd_data <= fast_modes_q;
                    tsw_pkg::SIDE_MODES_ADDR: reg_rd_data <= side_modes_q;
                    tsw_pkg::RX_SETTINGS_ADDR: reg_rd_data <= rx_settings_q;
                    tsw_pkg::TERM_PULSE_AB_ADDR: reg_rd_data <= term_pulse_select_q[7:0];
                    tsw_pkg::TERM_PULSE_CD_ADDR: reg_rd_data <= term_pulse_select_q[15:8];
                    tsw_pkg::EQ_SEL_AB_ADDR: reg_rd_data <= eq_sel_q[7:0];
                    tsw_pkg::EQ_SEL_CD_ADDR: reg_rd_data <= eq_sel_q[15:8];
                    tsw_pkg::TX_SETTINGS_ADDR: reg_rd_data <= tx_settings_q;
                    default: reg_rd_data <= 8'h00;
                endcase
            end
        end
    end

    // Routing decode of both switches
    always_comb begin
        fast_route_d = decode_route(fast_modes_q, 1'b0);
        side_route_d = decode_route(side_modes_q, 1'b1);
    end

    // Routing outputs come from flip-flops, one cycle behind the registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fast_route_q <= '0;
            side_route_q <= '0;
            fast_prev_q <= '0;
        end else begin
            fast_route_q <= fast_route_d;
            side_route_q <= side_route_d;
            fast_prev_q <= fast_route_q;
        end
    end

    // A source switch is any change of an enabled fast routing
    assign switch_event = (fast_route_q != fast_prev_q) && (fast_route_q.on != 4'h0);

    // Pulse timer; a new switch during a pulse restarts the full length
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pulse_cnt_q <= '0;
        end else if (switch_event) begin
            pulse_cnt_q <= CNT_W'(PULSE_CYCLES); // [R13]
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - 1'b1;
        end
    end

    assign pulse_active = (pulse_cnt_q != '0);

    // Per-channel termination and equalizer level, in channel order A0..D3
    for (genvar ch = 0; ch < 16; ch++) begin : g_chan
        logic [3:0] b;
        assign b = chan_bit(4'(ch));
        assign input_termination_on[ch] = rx_settings_q[tsw_pkg::RX_TO_BIT]
            & ~(pulse_active & term_pulse_select_q[b]); // [R11] [R13]
        assign equalizer_level_select[ch] = eq_sel_q[b]; // [R14]
    end

    // Output drive
    assign fast_route = fast_route_q;
    assign side_route = side_route_q;
    assign fast_standby = ~fast_route_q.on[0]; // [R1]
    assign tx_settings.output_emphasis_level = tx_settings_q[tsw_pkg::OUTPUT_EMPHASIS_LEVEL_LSB +: 2]; // [R16]
    assign tx_settings.output_termination_on = tx_settings_q[tsw_pkg::OUTPUT_TERMINATION_ON_BIT];
    assign tx_settings.output_current_level = tx_settings_q[tsw_pkg::OUTPUT_CURRENT_LEVEL_BIT];
endmodule

// File: tb/tsw_config_regs_assertions.sv
`timescale 1ns/1ps
// Port-level watch on the switch configuration registers
module tsw_config_regs_chk #(
    parameter int PULSE_CYCLES = 20,
    parameter int CNT_W = 25
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire tsw_pkg::tsw_route_s fast_route,
    input wire tsw_pkg::tsw_route_s side_route,
    input wire logic fast_standby,
    input wire logic [15:0] input_termination_on
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;
    logic [CNT_W-1:0] low_q;
    // Write byte delayed to line up with its route; run length of the A0 gap
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wd1_q <= 8'h00;
            wd2_q <= 8'h00;
            low_q <= '0;
        end else begin
            wd1_q <= reg_wr_data;
            wd2_q <= wd1_q;
            low_q <= input_termination_on[0] ? '0 : low_q + 1'b1;
        end
    end
    // A write that no second write to the same byte overtakes
    sequence wr_s(a, ok);
        reg_wr_en && reg_addr == a && ok ##1 !(reg_wr_en && reg_addr == a);
    endsequence
    // The flag follows the route flip-flops, two edges after the write edge
    standby_write_a: assert property (reg_wr_en && reg_addr == tsw_pkg::FAST_MODES_ADDR
        |-> ##2 fast_standby == !$past(reg_wr_data[6], 2)) else $error("standby flag wrong");
    standby_route_a: assert property (fast_standby [*3] |-> fast_route.on == 4'h0)
        else $error("fast lanes on in standby");
    active_route_a: assert property (!fast_standby [*3] |-> fast_route.on == 4'hf)
        else $error("fast lanes off while enabled");
    quad_route_a: assert property (wr_s(tsw_pkg::FAST_MODES_ADDR, reg_wr_data[6:4] == 3'h4)
        |=> fast_route.chan == {wd2_q[1:0], 2'h3, wd2_q[1:0], 2'h2, wd2_q[1:0], 2'h1,
        wd2_q[1:0], 2'h0}) else $error("quad routing wrong");
    dual_route_a: assert property (wr_s(tsw_pkg::FAST_MODES_ADDR, reg_wr_data[6:4] == 3'h5)
        |=> fast_route.chan == {wd2_q[2:0], 1'b1, wd2_q[2:0], 1'b1, wd2_q[2:0], 1'b0,
        wd2_q[2:0], 1'b0}) else $error("dual routing wrong");
    single_route_a: assert property (wr_s(tsw_pkg::FAST_MODES_ADDR, reg_wr_data[6:4] == 3'h6)
        |=> fast_route.chan == {4{wd2_q[3:0]}}) else $error("single routing wrong");
    side_off_a: assert property (wr_s(tsw_pkg::SIDE_MODES_ADDR, !reg_wr_data[6])
        |=> side_route.on == 4'h0) else $error("side switch on while disabled");
    pulse_length_a: assert property ($rose(input_termination_on[0])
        |-> low_q >= PULSE_CYCLES) else $error("termination gap too short");
endmodule
bind tsw_config_regs tsw_config_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) chk (
    .clock, .reset, .reg_wr_en, .reg_addr, .reg_wr_data, .fast_route, .side_route,
    .fast_standby, .input_termination_on);

// File: tb/tsw_host.sv
`timescale 1ns/1ps
// Configuring host at the byte level of its serial port
module tsw_host (
    input wire logic clock,
    output logic reg_wr_en = 1'b0,
    output logic reg_rd_en = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wr_data = 8'h00,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    // Address and data are scrambled once taken, so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask
    // Read strobe, then a bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clock);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            @(posedge clock);
            ok = reg_rd_valid;
            d = reg_rd_data;
        end
    endtask
endmodule

// File: tb/tsw_config_regs_tb.sv
`timescale 1ns/1ps
module tsw_config_regs_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, fast_standby;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [15:0] input_termination_on, equalizer_level_select;
    tsw_pkg::tsw_route_s fast_route, side_route;
    tsw_pkg::tsw_tx_s tx_settings;
    int n_mismatch = 0;
    int comparisons = 0;
    // Short pulse count keeps the termination scenario brief
    tsw_config_regs #(.PULSE_CYCLES(20)) uut (.clock, .reset, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid, .fast_route, .side_route,
        .fast_standby, .input_termination_on, .equalizer_level_select, .tx_settings);
    tsw_host host (.clock, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .reg_rd_valid);
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A read that never answers ends the run
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
        check(d, exp);
    endtask
    // Lane map for a mode and select code; side dual pairs A/C and B/D
    function automatic logic [15:0] route_of(input logic [1:0] m, input logic [3:0] c,
        input logic sd);
        logic [3:0] lo, hi;
        lo = sd ? {1'b0, c[2:0]} : {c[2:0], 1'b0};
        hi = sd ? lo | 4'h8 : lo | 4'h1;
        if (m == 2'h0) return {c[1:0], 2'h3, c[1:0], 2'h2, c[1:0], 2'h1, c[1:0], 2'h0};
        if (m == 2'h1) return {hi, hi, lo, lo};
        return {4{c}};
    endfunction
    // Defaults on outputs and in every register; 0x05 is unmapped
    task automatic t_reset();
        logic [7:0] a [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h05};
        logic [7:0] v [9] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
        repeat (2) @(posedge clock);
        #1;
        check({fast_route, side_route}, {4'hf, route_of(0, 0, 0), 4'hf, route_of(0, 0, 1)});
        check({fast_standby, input_termination_on, equalizer_level_select, tx_settings},
            {1'b0, 16'hffff, 16'h0000, 4'h3});
        for (int i = 0; i < 9; i++) begin
            rd_check(a[i], v[i]);
        end
    endtask
    // Every emphasis code, equalizer bit order and read-back of set bytes
    task automatic t_regs();
        for (int p = 0; p < 4; p++) begin
            host.wr(8'h20, {4'hf, p[1:0], 2'h1});
            #1;
            check(tx_settings, {p[1:0], 2'h1});
        end
        host.wr(8'h13, 8'h10);
        host.wr(8'h14, 8'h01);
        host.wr(8'h12, 8'h5a);
        #1;
        check(equalizer_level_select, 16'h0801);
        rd_check(8'h20, 8'h0d);
        rd_check(8'h12, 8'h5a);
        host.wr(8'h12, 8'h00);
    endtask
    // All legal modes and select codes on both switches
    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 16; c++) begin
                host.wr(8'h00, {2'b01, m[1:0], c[3:0]});
                host.wr(8'h01, {2'b01, m[1:0], c[3:0]});
                @(posedge clock);
                #1;
                check(fast_route, {4'hf, route_of(m[1:0], c[3:0], 0)});
                check(side_route, {4'hf, route_of(m[1:0], c[3:0], 1)});
            end
        end
    endtask
    // Code 11 is refused while enable and select still land; then standby
    task automatic t_illegal();
        host.wr(8'h00, 8'h55);
        host.wr(8'h00, 8'h73);
        host.wr(8'h01, 8'h6a);
        host.wr(8'h01, 8'h31);
        rd_check(8'h00, 8'h53);
        rd_check(8'h01, 8'h21);
        check(fast_route, {4'hf, route_of(1, 3, 0)});
        check(side_route.on, 4'h0);
        host.wr(8'h00, 8'h13);
        // Standby follows the routing flip-flops, one edge after the register
        @(posedge clock);
        #1;
        check(fast_standby, 1'b1);
        @(posedge clock);
        #1;
        check(fast_route.on, 4'h0);
        host.wr(8'h00, 8'h40);
        host.wr(8'h01, 8'h40);
    endtask
    // Only A0 has its pulse bit; its gap lasts the full count
    task automatic t_pulse();
        int n = 0;
        logic [14:0] rest = 15'h7fff;
        // Let the pulse from the last re-enable run out before arming A0
        repeat (30) @(posedge clock);
        host.wr(8'h11, 8'h10);
        host.wr(8'h00, 8'h41);
        repeat (40) begin
            @(posedge clock);
            #1;
            n += int'(input_termination_on[0] === 1'b0);
            rest &= input_termination_on[15:1];
        end
        check(n, 20);
        check(rest, 15'h7fff);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_illegal();
        t_pulse();
        summarize();
    end
endmodule
